// [core/evpd_pkg.sv]
// Constants shared by the exception vector priority decoder.
// Assumes a 32-bit APB register bus and a CPU core that fetches vectors on request.

package evpd_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [7:0]  REG_VBU        = 8'h00;
  localparam logic [7:0]  REG_STATUS     = 8'h04;
  localparam logic [7:0]  REG_MASK       = 8'h08;
  localparam logic [7:0]  REG_LAST_VEC   = 8'h0C;
  localparam logic [7:0]  VBU_RESET      = 8'hFF;
  localparam logic [31:0] RDATA_ZERO     = 32'h0000_0000;

  // ********************************************************************
  // Event bits of status and mask
  // ********************************************************************
  localparam int          EV_W           = 2;
  localparam int          EV_SPURIOUS    = 0;
  localparam int          EV_WAKE        = 1;
  localparam logic [1:0]  EV_RESET       = 2'h0;

  // ********************************************************************
  // Vector addresses and offsets
  // ********************************************************************
  localparam logic [7:0]  FREEZE_BASE    = 8'hFF;
  localparam logic [7:0]  BASE_LOW       = 8'h00;
  localparam logic [15:0] VEC_RST_PIN    = 16'hFFFE;
  localparam logic [15:0] VEC_RST_CLKMON = 16'hFFFC;
  localparam logic [15:0] VEC_RST_WDOG   = 16'hFFFA;
  localparam logic [7:0]  OFS_TRAP       = 8'hF8;
  localparam logic [7:0]  OFS_SWI        = 8'hF6;
  localparam logic [7:0]  OFS_XPIN       = 8'hF4;
  localparam logic [7:0]  OFS_PINLINK    = 8'hF2;
  localparam logic [7:0]  OFS_PERIPH_LOW = 8'h82;
  localparam logic [7:0]  OFS_SPURIOUS   = 8'h80;
  localparam int          MAX_PERIPH     = 56;
  localparam logic [15:0] VEC_RESET_VAL  = 16'hFFFE;

endpackage

// [core/evpd_top.sv]
// Exception vector priority decoder with its APB register file.
// Assumes all inputs are synchronous to pclk and that the CPU pulses
// vec_req for one cycle per vector fetch.

module evpd_top #(
  parameter int N_PERIPH = 56                      // Peripheral request lines
) (
  input  wire logic                pclk,           // Bus clock
  input  wire logic                presetn,        // System reset, active low
  input  wire logic                psel,           // APB select
  input  wire logic                penable,        // APB access phase
  input  wire logic                pwrite,         // APB write direction
  input  wire logic [7:0]          paddr,          // APB byte address
  input  wire logic [31:0]         pwdata,         // APB write data
  output logic      [31:0]         prdata,         // APB read data
  output logic                     pready,         // APB ready
  output logic                     pslverr,        // APB error, unmapped address
  input  wire logic [2:0]          reset_cause,    // Pin or power-on, clock monitor, watchdog
  input  wire logic                reset_fetch,    // Current fetch is the reset vector
  input  wire logic                vec_req,        // CPU vector request pulse
  output logic      [15:0]         vec_addr,       // Supplied vector address
  output logic                     vec_valid,      // Vector address valid pulse
  input  wire logic                illegal_opcode_req,    // Unimplemented opcode trap
  input  wire logic                software_trap_request, // Software trap or debug request
  input  wire logic                priority_pin_request,  // Priority maskable request
  input  wire logic                pin_link_request,      // Pin or link general request
  input  wire logic [N_PERIPH-1:0] periph_req,     // Peripheral general requests
  input  wire logic [N_PERIPH-1:0] periph_en,      // Peripheral local enables
  input  wire logic                i_mask,         // General mask flag of the CPU
  input  wire logic                x_mask,         // Priority mask flag of the CPU
  input  wire logic                freeze,         // Debug freeze mode active
  input  wire logic                low_power,      // CPU is in wait or stop
  output logic                     wake_cpu,       // Wake request to the CPU
  output logic                     irq             // Event interrupt, active high
);

  // ********************************************************************
  // Parameter check
  // ********************************************************************
  generate
    if (N_PERIPH < 1 || N_PERIPH > evpd_pkg::MAX_PERIPH)
    begin : g_bad_n
      $error("N_PERIPH must lie between 1 and 56.");
    end
  endgenerate

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic [7:0]            vbu;
    logic [evpd_pkg::EV_W-1:0] status;
    logic [evpd_pkg::EV_W-1:0] mask;
    logic [15:0]           last_vec;
    logic [15:0]           vec_addr;
    logic                  vec_valid;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  irq;
    logic                  wake_q;
  } evpd_state_t;

  evpd_state_t st;
  evpd_state_t next_st;

  logic [7:0]                base;
  logic                      xpin_ok;
  logic                      gen_ok;
  logic                      gen_any;
  logic                      found;
  logic [7:0]                low;
  logic                      periph_found;
  logic [7:0]                periph_low;
  logic [15:0]               reset_vec;
  logic [15:0]               chosen;
  logic                      wake_now;
  logic                      setup;
  logic                      access;
  logic                      mapped;
  logic [31:0]               rd_mux;
  logic [evpd_pkg::EV_W-1:0] ev_set;
  logic [evpd_pkg::EV_W-1:0] ev_clr;

  // ********************************************************************
  // Priority decode
  // ********************************************************************
  always_comb
  begin
    // Freeze overrides the programmed byte so debug firmware always finds its handlers.
    base    = freeze ? evpd_pkg::FREEZE_BASE : st.vbu;
    xpin_ok = priority_pin_request && !x_mask;
    gen_ok  = !i_mask && !illegal_opcode_req && !software_trap_request
              && !xpin_ok;
    periph_found = 1'b0;
    periph_low   = evpd_pkg::OFS_SPURIOUS;
    // Higher index means a higher low byte, so the last hit wins.
    for (int k = 0; k < N_PERIPH; k++)
    begin
      if (periph_req[k] && periph_en[k])
      begin
        periph_found = 1'b1;
        periph_low   = 8'(int'(evpd_pkg::OFS_PERIPH_LOW) + 2 * k);
      end
    end
    found = 1'b1;
    if (illegal_opcode_req)
    begin
      low = evpd_pkg::OFS_TRAP;
    end
    else if (software_trap_request)
    begin
      low = evpd_pkg::OFS_SWI;
    end
    else if (xpin_ok)
    begin
      low = evpd_pkg::OFS_XPIN;
    end
    else if (gen_ok && pin_link_request)
    begin
      low = evpd_pkg::OFS_PINLINK;
    end
    else if (gen_ok && periph_found)
    begin
      low = periph_low;
    end
    else
    begin
      found = 1'b0;
      low   = evpd_pkg::OFS_SPURIOUS;
    end
    if (reset_cause[0])
    begin
      reset_vec = evpd_pkg::VEC_RST_PIN;
    end
    else if (reset_cause[1])
    begin
      reset_vec = evpd_pkg::VEC_RST_CLKMON;
    end
    else if (reset_cause[2])
    begin
      reset_vec = evpd_pkg::VEC_RST_WDOG;
    end
    else
    begin
      reset_vec = evpd_pkg::VEC_RST_PIN;
    end
    // Reset vectors ignore the base register entirely.
    chosen = reset_fetch ? reset_vec : {base, low};
  end

  // ********************************************************************
  // Wake path
  // ********************************************************************
  // The clock is gated in wait and stop, so the wake request cannot wait for
  // an edge and is formed from the request lines directly.
  always_comb
  begin
    gen_any  = pin_link_request || (|(periph_req & periph_en));
    wake_now = low_power && (priority_pin_request
               || (gen_any && !i_mask));
  end

  assign wake_cpu = wake_now;

  // ********************************************************************
  // Register file and next state
  // ********************************************************************
  always_comb
  begin
    next_st = st;
    setup   = psel && !penable;
    access  = psel && penable && st.pready;
    mapped  = (paddr == evpd_pkg::REG_VBU) || (paddr == evpd_pkg::REG_STATUS)
              || (paddr == evpd_pkg::REG_MASK) || (paddr == evpd_pkg::REG_LAST_VEC);
    unique case (paddr)
      evpd_pkg::REG_VBU:      rd_mux = {24'h00_0000, st.vbu};
      evpd_pkg::REG_STATUS:   rd_mux = {30'h0000_0000, st.status};
      evpd_pkg::REG_MASK:     rd_mux = {30'h0000_0000, st.mask};
      evpd_pkg::REG_LAST_VEC: rd_mux = {16'h0000, st.last_vec};
      default:                rd_mux = evpd_pkg::RDATA_ZERO;
    endcase

    // Zero wait states: ready is raised for the first access cycle only.
    next_st.pready = setup;
    if (setup)
    begin
      next_st.pslverr = !mapped;
      next_st.prdata  = (pwrite || !mapped) ? evpd_pkg::RDATA_ZERO : rd_mux;
    end
    else if (!psel)
    begin
      next_st.pslverr = 1'b0;
    end

    ev_clr = '0;
    if (access && pwrite)
    begin
      if (paddr == evpd_pkg::REG_VBU)
      begin
        next_st.vbu = pwdata[7:0];
      end
      if (paddr == evpd_pkg::REG_STATUS)
      begin
        ev_clr = pwdata[evpd_pkg::EV_W-1:0];
      end
      if (paddr == evpd_pkg::REG_MASK)
      begin
        next_st.mask = pwdata[evpd_pkg::EV_W-1:0];
      end
    end

    // The vector is chosen in the cycle of the request, never earlier.
    next_st.vec_valid = vec_req;
    ev_set = '0;
    if (vec_req)
    begin
      next_st.vec_addr = chosen;
      next_st.last_vec = chosen;
      ev_set[evpd_pkg::EV_SPURIOUS] = !found && !reset_fetch;
    end
    next_st.wake_q = wake_now;
    ev_set[evpd_pkg::EV_WAKE] = wake_now && !st.wake_q;

    // A new event beats a clear arriving in the same cycle.
    next_st.status = (st.status & ~ev_clr) | ev_set;
    next_st.irq    = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st.vbu       <= evpd_pkg::VBU_RESET;
      st.status    <= evpd_pkg::EV_RESET;
      st.mask      <= evpd_pkg::EV_RESET;
      st.last_vec  <= evpd_pkg::VEC_RESET_VAL;
      st.vec_addr  <= evpd_pkg::VEC_RESET_VAL;
      st.vec_valid <= 1'b0;
      st.prdata    <= evpd_pkg::RDATA_ZERO;
      st.pready    <= 1'b0;
      st.pslverr   <= 1'b0;
      st.irq       <= 1'b0;
      st.wake_q    <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign prdata    = st.prdata;
  assign pready    = st.pready;
  assign pslverr   = st.pslverr;
  assign vec_addr  = st.vec_addr;
  assign vec_valid = st.vec_valid;
  assign irq       = st.irq;

endmodule

// [testbench/evpd_sva.sv]
// Checker for the exception vector priority decoder, watching top ports only.
// Assumes it is bound into every instance of the decoder's top module.
module evpd_sva #(
  parameter int N_PERIPH = 56
) (
  input wire logic        pclk,                  // Bus clock
  input wire logic        presetn,               // Reset, active low
  input wire logic        psel,                  // APB select
  input wire logic        penable,               // APB access phase
  input wire logic        pready,                // APB ready
  input wire logic [2:0]  reset_cause,           // Reset cause bits
  input wire logic        reset_fetch,           // Reset vector fetch
  input wire logic        vec_req,               // Vector request
  input wire logic [15:0] vec_addr,              // Supplied vector
  input wire logic        vec_valid,             // Vector strobe
  input wire logic        illegal_opcode_req,    // Opcode trap
  input wire logic        software_trap_request, // Software trap
  input wire logic        priority_pin_request,  // Priority request
  input wire logic        i_mask,                // General mask flag
  input wire logic        freeze,                // Debug freeze
  input wire logic        low_power,             // Wait or stop
  input wire logic        wake_cpu,              // Wake request
  input wire logic        irq                    // Event interrupt
);
  timeunit 1ns;
  timeprecision 100ps;
  // ******************************************************************
  // Properties
  // ******************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_vec_answer: assert property (vec_req |=> vec_valid)
    else $error("vector request not answered next cycle");
  chk_vec_quiet: assert property (!vec_req |=> !vec_valid && $stable(vec_addr))
    else $error("vector output moved without a request");
  chk_reset_top: assert property (vec_req && reset_fetch && reset_cause[0] |=>
    vec_addr == 16'hFFFE) else $error("top reset vector wrong");
  chk_reset_wdog: assert property (vec_req && reset_fetch && reset_cause == 3'h4 |=>
    vec_addr == 16'hFFFA) else $error("watchdog reset vector wrong");
  chk_freeze_trap: assert property (vec_req && !reset_fetch && freeze &&
    illegal_opcode_req |=> vec_addr == 16'hFFF8) else $error("frozen trap vector wrong");
  chk_masked_spur: assert property (vec_req && !reset_fetch && i_mask &&
    !illegal_opcode_req && !software_trap_request && !priority_pin_request |=>
    vec_addr[7:0] == 8'h80) else $error("masked general request not spurious");
  chk_wake_block: assert property (low_power && i_mask && !priority_pin_request |->
    !wake_cpu) else $error("masked request woke the core");
  chk_wake_prio: assert property (low_power && priority_pin_request |-> wake_cpu)
    else $error("priority request did not wake the core");
  chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single cycle after setup");

  cover property (vec_req && reset_fetch);
  cover property (vec_req && freeze);
  cover property (irq);
  cover property (low_power && wake_cpu);
endmodule

bind evpd_top evpd_sva #(.N_PERIPH(N_PERIPH)) u_sva (.*);

// [testbench/evpd_cpu_model.sv]
// Model of the CPU core that fetches vectors from the decoder.
// Assumes one answer strobe follows each single-cycle request.
module evpd_cpu_model (
  input  wire logic        pclk,       // Bus clock
  input  wire logic        vec_valid,  // Answer strobe
  input  wire logic [15:0] vec_addr,   // Answered vector
  output logic             vec_req,    // Request pulse
  output logic             reset_fetch // Reset vector fetch
);
  timeunit 1ns;
  timeprecision 100ps;
  // ******************************************************************
  // Fetch
  // ******************************************************************
  initial
  begin
    vec_req = 1'b0;
    reset_fetch = 1'b0;
  end

  // The answer is taken at the edge where the strobe is sampled high; only the
  // bench timeout ends a wait that never sees it.
  task automatic fetch(input logic rf, output logic [15:0] addr);
    @(posedge pclk);
    vec_req <= 1'b1;
    reset_fetch <= rf;
    @(posedge pclk);
    vec_req <= 1'b0;
    reset_fetch <= 1'b0;
    do
      @(posedge pclk);
    while (vec_valid !== 1'b1);
    addr = vec_addr;
  endtask
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the exception vector priority decoder.
// Assumes the core model issues fetches and the checker is bound in.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0]  ctl; // rf, trap, swi, prio, xmask, pinlink, imask, freeze
    logic [2:0]  cause;
    logic [3:0]  preq;
    logic [3:0]  pen;
    logic [15:0] exp;
  } evpd_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, wake_cpu;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] reset_cause;
  logic reset_fetch, vec_req, vec_valid, err, low_power, freeze, i_mask, x_mask;
  logic illegal_opcode_req, software_trap_request, priority_pin_request, pin_link_request;
  logic [15:0] vec_addr, va;
  logic [3:0] periph_req, periph_en;
  int err_count, comparisons, cycles;
  evpd_row_t rows [15] = '{'{8'h80, 3'h7, 4'h0, 4'h0, 16'hFFFE}, '{8'h80, 3'h6, 4'h0, 4'h0,
    16'hFFFC}, '{8'h80, 3'h4, 4'h0, 4'h0, 16'hFFFA}, '{8'h80, 3'h0, 4'h0, 4'h0, 16'hFFFE},
    '{8'h70, 3'h0, 4'hF, 4'hF, 16'h3CF8}, '{8'h34, 3'h0, 4'hF, 4'hF, 16'h3CF6},
    '{8'h14, 3'h0, 4'hF, 4'hF, 16'h3CF4}, '{8'h1C, 3'h0, 4'h0, 4'h0, 16'h3CF2},
    '{8'h04, 3'h0, 4'hF, 4'hF, 16'h3CF2}, '{8'h00, 3'h0, 4'h5, 4'hF, 16'h3C86},
    '{8'h00, 3'h0, 4'hF, 4'h3, 16'h3C84}, '{8'h06, 3'h0, 4'hF, 4'hF, 16'h3C80},
    '{8'h00, 3'h0, 4'h0, 4'h0, 16'h3C80}, '{8'h41, 3'h0, 4'h0, 4'h0, 16'hFFF8},
    '{8'h21, 3'h0, 4'h0, 4'h0, 16'hFFF6}};

  evpd_top #(.N_PERIPH(4)) DUT (.*);
  evpd_cpu_model cpu (.*);

  always #2 pclk = ~pclk;

  // ******************************************************************
  // Tasks
  // ******************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      err_count++;
      end_of_test();
    end
  end

  // ******************************************************************
  // Sequence
  // ******************************************************************
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, reset_cause, periph_req, periph_en} = '0;
    {illegal_opcode_req, software_trap_request, priority_pin_request} = '0;
    {x_mask, pin_link_request, i_mask, freeze, low_power} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0000_0000);
    check("base reset", rd, 32'h0000_00FF);
    apb(1'b1, 8'h00, 32'h0000_013C);
    apb(1'b0, 8'h00, 32'h0000_0000);
    check("base readback", rd, 32'h0000_003C);
    foreach (rows[i])
    begin
      @(posedge pclk);
      {illegal_opcode_req, software_trap_request, priority_pin_request} <= rows[i].ctl[6:4];
      {x_mask, pin_link_request, i_mask, freeze} <= rows[i].ctl[3:0];
      {reset_cause, periph_req, periph_en} <= {rows[i].cause, rows[i].preq, rows[i].pen};
      cpu.fetch(rows[i].ctl[7], va);
      check("vector", {16'h0000, va}, {16'h0000, rows[i].exp});
    end
    $display("test vector table done");
    apb(1'b0, 8'h10, 32'h0000_0000);
    check("unmapped error", {31'h0, err}, 32'h0000_0001);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    check("last vector", rd, 32'h0000_FFF6);
    {software_trap_request, freeze} <= 2'h0;
    apb(1'b1, 8'h04, 32'h0000_0003);
    apb(1'b1, 8'h08, 32'h0000_0001);
    cpu.fetch(1'b0, va);
    check("spurious vector", {16'h0000, va}, 32'h0000_3C80);
    check("irq set", {31'h0, irq}, 32'h0000_0001);
    apb(1'b1, 8'h08, 32'h0000_0000);
    @(posedge pclk);
    check("irq masked", {31'h0, irq}, 32'h0000_0000);
    apb(1'b1, 8'h08, 32'h0000_0001);
    apb(1'b1, 8'h04, 32'h0000_0001);
    @(posedge pclk);
    check("irq cleared", {31'h0, irq}, 32'h0000_0000);
    $display("test interrupt done");
    @(posedge pclk);
    {low_power, i_mask, pin_link_request, priority_pin_request, x_mask} <= 5'h1C;
    #1 check("wake masked", {31'h0, wake_cpu}, 32'h0000_0000);
    @(posedge pclk) {i_mask} <= 1'b0;
    #1 check("wake general", {31'h0, wake_cpu}, 32'h0000_0001);
    @(posedge pclk) {low_power, i_mask, pin_link_request, priority_pin_request, x_mask} <= 5'h1B;
    #1 check("wake priority", {31'h0, wake_cpu}, 32'h0000_0001);
    apb(1'b0, 8'h04, 32'h0000_0000);
    check("wake event", rd, 32'h0000_0002);
    $display("test wake done");
    @(posedge pclk) presetn <= 1'b0;
    @(posedge pclk) presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0000_0000);
    check("base second reset", rd, 32'h0000_00FF);
    $display("test second reset done");
    end_of_test();
  end
endmodule
